// ### asts_server.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asts_server (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_done,
  output logic      [15:0] conv_cmd,
  output logic             conv_cmd_wr,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             service_request
);
  asts_pkg::asts_state_t state_q;
  logic [8:0]  ctrl_q;
  logic [7:0]  cycle_count_q;
  logic [15:0] table_pointer_q;
  logic [15:0] result_reg_pointer_q;
  logic [15:0] start1_q;
  logic [15:0] start2_q;
  logic [5:0]  block_length_q;
  logic [5:0]  remain_q;
  logic [15:0] cmd_hold_q;
  logic        srv_q;
  logic        pend_q;
  logic        pend_d;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [15:0] conv_cmd_q;
  logic        conv_wr_q;
  logic        mem_req_q;
  logic        mem_we_q;
  logic        mem_byte_q;
  logic [15:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic        wr_take;
  logic        take;
  logic [2:0]  mode;
  logic [15:0] step;
  logic [31:0] rd_data;
  logic        hit;

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign conv_cmd        = conv_cmd_q;
  assign conv_cmd_wr     = conv_wr_q;
  assign mem_req         = mem_req_q;
  assign mem_we          = mem_we_q;
  assign mem_byte        = mem_byte_q;
  assign mem_addr        = mem_addr_q;
  assign mem_wdata       = mem_wdata_q;
  assign service_request = srv_q;

  assign wr_take = psel && penable && pwrite && pready_q;
  assign mode    = ctrl_q[asts_pkg::MODE_HI:asts_pkg::MODE_LO];
  assign step    = ctrl_q[asts_pkg::BIT_BW] ? asts_pkg::STEP_BYTE : asts_pkg::STEP_WORD;
  // Select gates the start too, so a pending event latched in the final cycle is dropped
  assign take    = (state_q == asts_pkg::ST_IDLE) && pend_q && ctrl_q[asts_pkg::BIT_SEL];

  // Event latch; an event on the take cycle is kept for the next cycle
  always_comb begin
    pend_d = ctrl_q[asts_pkg::BIT_SEL] && ((pend_q && !take) || conv_done);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      pend_q <= pend_d;
    end
  end

  // Read mux
  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      asts_pkg::OFF_CTRL:  rd_data[8:0]  = ctrl_q;
      asts_pkg::OFF_COUNT: rd_data[7:0]  = cycle_count_q;
      asts_pkg::OFF_PTR1:  rd_data[15:0] = table_pointer_q;
      asts_pkg::OFF_PTR2:  rd_data[15:0] = result_reg_pointer_q;
      asts_pkg::OFF_BLOCK: rd_data[5:0]  = block_length_q;
      asts_pkg::OFF_STAT: begin
        rd_data[asts_pkg::ST_SRV]  = srv_q;
        rd_data[asts_pkg::ST_BUSY] = (state_q != asts_pkg::ST_IDLE);
        rd_data[asts_pkg::ST_PEND] = pend_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // One wait state on every access
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && penable && !pready_q) begin
        pready_q  <= 1'b1;
        pslverr_q <= !hit;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Sequencer; software writes land here too so each register has one driver
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q              <= asts_pkg::ST_IDLE;
      ctrl_q               <= asts_pkg::RST_CTRL;
      cycle_count_q        <= asts_pkg::RST_COUNT;
      table_pointer_q      <= asts_pkg::RST_PTR;
      result_reg_pointer_q <= asts_pkg::RST_PTR;
      start1_q             <= asts_pkg::RST_PTR;
      start2_q             <= asts_pkg::RST_PTR;
      block_length_q       <= asts_pkg::RST_BLOCK;
      remain_q             <= asts_pkg::RST_BLOCK;
      cmd_hold_q           <= asts_pkg::RST_PTR;
      srv_q                <= 1'b0;
      conv_cmd_q           <= asts_pkg::RST_PTR;
      conv_wr_q            <= 1'b0;
      mem_req_q            <= 1'b0;
      mem_we_q             <= 1'b0;
      mem_byte_q           <= 1'b0;
      mem_addr_q           <= asts_pkg::RST_PTR;
      mem_wdata_q          <= asts_pkg::RST_PTR;
    end else if (ce) begin
      conv_wr_q <= 1'b0;
      if (wr_take) begin
        case (paddr)
          asts_pkg::OFF_CTRL:  ctrl_q               <= pwdata[8:0];
          asts_pkg::OFF_COUNT: cycle_count_q        <= pwdata[7:0];
          asts_pkg::OFF_PTR1:  table_pointer_q      <= pwdata[15:0];
          asts_pkg::OFF_PTR2:  result_reg_pointer_q <= pwdata[15:0];
          asts_pkg::OFF_BLOCK: block_length_q       <= pwdata[5:0];
          asts_pkg::OFF_STAT:  if (pwdata[asts_pkg::ST_SRV]) srv_q <= 1'b0;
          default: ;
        endcase
      end
      case (state_q)
        asts_pkg::ST_IDLE: begin
          if (take) begin
            start1_q <= table_pointer_q;
            start2_q <= result_reg_pointer_q;
            if (mode == asts_pkg::MODE_SCAN) begin
              mem_req_q  <= 1'b1;
              mem_we_q   <= 1'b0;
              mem_byte_q <= 1'b0;
              mem_addr_q <= table_pointer_q;
              state_q    <= asts_pkg::ST_RD_CMD;
            end else if (mode == asts_pkg::MODE_BLOCK) begin
              remain_q   <= block_length_q;
              mem_req_q  <= 1'b1;
              mem_we_q   <= 1'b0;
              mem_byte_q <= ctrl_q[asts_pkg::BIT_BW];
              mem_addr_q <= table_pointer_q;
              state_q    <= asts_pkg::ST_BLK_RD;
            end
          end
        end
        asts_pkg::ST_RD_CMD: begin
          if (mem_ack) begin
            cmd_hold_q      <= mem_rdata;
            table_pointer_q <= table_pointer_q + asts_pkg::STEP_WORD;
            mem_addr_q      <= result_reg_pointer_q;
            state_q         <= asts_pkg::ST_RD_RES;
          end
        end
        asts_pkg::ST_RD_RES: begin
          if (mem_ack) begin
            mem_we_q    <= 1'b1;
            mem_addr_q  <= table_pointer_q;
            mem_wdata_q <= mem_rdata;
            state_q     <= asts_pkg::ST_WR_RES;
          end
        end
        asts_pkg::ST_WR_RES: begin
          if (mem_ack) begin
            mem_req_q       <= 1'b0;
            mem_we_q        <= 1'b0;
            table_pointer_q <= table_pointer_q + asts_pkg::STEP_WORD;
            conv_cmd_q      <= cmd_hold_q;
            conv_wr_q       <= 1'b1;
            state_q         <= asts_pkg::ST_WR_CMD;
          end
        end
        asts_pkg::ST_WR_CMD: state_q <= asts_pkg::ST_FINISH;
        asts_pkg::ST_BLK_RD: begin
          if (mem_ack) begin
            if (ctrl_q[asts_pkg::BIT_SI]) begin
              table_pointer_q <= table_pointer_q + step;
            end
            mem_we_q    <= 1'b1;
            mem_addr_q  <= result_reg_pointer_q;
            mem_wdata_q <= mem_rdata;
            state_q     <= asts_pkg::ST_BLK_WR;
          end
        end
        asts_pkg::ST_BLK_WR: begin
          if (mem_ack) begin
            if (ctrl_q[asts_pkg::BIT_DI]) begin
              result_reg_pointer_q <= result_reg_pointer_q + step;
            end
            remain_q   <= remain_q - asts_pkg::BLOCK_ONE;
            mem_we_q   <= 1'b0;
            mem_addr_q <= table_pointer_q;
            if (remain_q == asts_pkg::BLOCK_ONE) begin
              mem_req_q <= 1'b0;
              state_q   <= asts_pkg::ST_FINISH;
            end else begin
              state_q <= asts_pkg::ST_BLK_RD;
            end
          end
        end
        asts_pkg::ST_FINISH: begin
          if (!ctrl_q[asts_pkg::BIT_SU]) begin
            table_pointer_q <= start1_q;
          end
          if (mode == asts_pkg::MODE_BLOCK && !ctrl_q[asts_pkg::BIT_DU]) begin
            result_reg_pointer_q <= start2_q;
          end
          cycle_count_q <= cycle_count_q - asts_pkg::COUNT_ONE;
          if (cycle_count_q == asts_pkg::COUNT_ONE) begin
            ctrl_q[asts_pkg::BIT_SEL] <= 1'b0;
            srv_q                     <= 1'b1;
          end
          state_q <= asts_pkg::ST_IDLE;
        end
        default: state_q <= asts_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking chk_cb @(posedge clk iff ce);
  endclocking
  default disable iff (reset);

  chk_take_scan: assert property (take && mode == asts_pkg::MODE_SCAN |=>
    state_q == asts_pkg::ST_RD_CMD && mem_req_q && !mem_we_q && mem_addr_q == start1_q)
    else $error("scan cycle did not start with command read");
  chk_cmd_ptr: assert property (state_q == asts_pkg::ST_RD_CMD && mem_ack |=>
    table_pointer_q == start1_q + asts_pkg::STEP_WORD && cmd_hold_q == $past(mem_rdata))
    else $error("command hold or pointer advance wrong");
  chk_result_slot: assert property (state_q == asts_pkg::ST_WR_RES && mem_req_q |->
    mem_we_q && mem_addr_q == start1_q + asts_pkg::STEP_WORD)
    else $error("result stored at wrong slot");
  chk_res_data: assert property (state_q == asts_pkg::ST_RD_RES && mem_ack |=>
    mem_wdata_q == $past(mem_rdata) && mem_we_q)
    else $error("result data not carried to store");
  chk_cmd_order: assert property (state_q == asts_pkg::ST_WR_RES && mem_ack |=>
    conv_wr_q && !mem_req_q ##1 !conv_wr_q && state_q == asts_pkg::ST_FINISH)
    else $error("command write out of order");
  chk_cmd_value: assert property ($rose(conv_wr_q) |-> conv_cmd_q == cmd_hold_q)
    else $error("converter got a different command");
  chk_ptr_restore: assert property (state_q == asts_pkg::ST_FINISH && !wr_take |=>
    table_pointer_q == ($past(ctrl_q[asts_pkg::BIT_SU]) ? $past(table_pointer_q) : $past(start1_q)))
    else $error("pointer update bit not honoured");
  chk_count_dec: assert property (state_q == asts_pkg::ST_FINISH && !wr_take |=>
    cycle_count_q == $past(cycle_count_q) - asts_pkg::COUNT_ONE && state_q == asts_pkg::ST_IDLE)
    else $error("cycle count not decremented");
  chk_end_flags: assert property (state_q == asts_pkg::ST_FINISH && cycle_count_q == asts_pkg::COUNT_ONE
    && !wr_take |=> !ctrl_q[asts_pkg::BIT_SEL] && srv_q)
    else $error("end of count flags wrong");
  chk_ignore_off: assert property (!ctrl_q[asts_pkg::BIT_SEL] && state_q == asts_pkg::ST_IDLE
    |=> state_q == asts_pkg::ST_IDLE)
    else $error("cycle started with server deselected");
  chk_blk_source: assert property (state_q == asts_pkg::ST_FINISH && mode == asts_pkg::MODE_BLOCK
    && !ctrl_q[asts_pkg::BIT_SU] && !wr_take |=> table_pointer_q == $past(start1_q))
    else $error("block source not restarted");

  cov_scan_cycle: cover property (state_q == asts_pkg::ST_WR_CMD ##2 take);
  cov_scan_end: cover property (state_q == asts_pkg::ST_FINISH && cycle_count_q == asts_pkg::COUNT_ONE);
  cov_blk_multi: cover property (state_q == asts_pkg::ST_BLK_WR && mem_ack && remain_q > asts_pkg::BLOCK_ONE);
endmodule : asts_server
`default_nettype wire

// ### asts_pkg.sv
`default_nettype none
package asts_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_PTR1  = 8'h08;
  localparam logic [7:0] OFF_PTR2  = 8'h0C;
  localparam logic [7:0] OFF_BLOCK = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;
  // Control byte fields, server select sits above it
  localparam int BIT_DI  = 0;
  localparam int BIT_SI  = 1;
  localparam int BIT_DU  = 2;
  localparam int BIT_SU  = 3;
  localparam int BIT_BW  = 4;
  localparam int BIT_SEL = 8;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam logic [2:0] MODE_SCAN  = 3'h6;
  localparam logic [2:0] MODE_BLOCK = 3'h0;
  // Status fields
  localparam int ST_SRV  = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PEND = 2;
  // Reset values and steps
  localparam logic [8:0]  RST_CTRL   = 9'h000;
  localparam logic [7:0]  RST_COUNT  = 8'h00;
  localparam logic [15:0] RST_PTR    = 16'h0000;
  localparam logic [5:0]  RST_BLOCK  = 6'h01;
  localparam logic [15:0] STEP_WORD  = 16'h0002;
  localparam logic [15:0] STEP_BYTE  = 16'h0001;
  localparam logic [7:0]  COUNT_ONE  = 8'h01;
  localparam logic [5:0]  BLOCK_ONE  = 6'h01;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_CMD, ST_RD_RES, ST_WR_RES, ST_WR_CMD, ST_BLK_RD, ST_BLK_WR, ST_FINISH
  } asts_state_t;
endpackage : asts_pkg
`default_nettype wire

// ### asts_partner.sv
`timescale 1ns/1ps
`default_nettype none
module asts_partner #(
  parameter logic [15:0] RES_ADDR = 16'h00F0,
  parameter int          CONV_LAT = 6
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        kick,
  input  wire logic [15:0] kick_cmd,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  input  wire logic [15:0] conv_cmd,
  input  wire logic        conv_cmd_wr,
  output logic             conv_done
);
  logic [15:0] mem [0:255];
  logic [15:0] res_q;
  logic [15:0] cmd_q;
  int          conv_cnt;
  int          wait_cnt;
  // Behavioural, so the bench may preload the table directly
  always @(posedge clk) begin
    mem_ack   <= 1'b0;
    conv_done <= 1'b0;
    mem_rdata <= ~mem_rdata;  // Idle bus alternates between the last data and its inverse
    if (reset) begin
      conv_cnt  <= 0;
      wait_cnt  <= 0;
      res_q     <= 16'h0000;
      mem_rdata <= 16'h0000;
    end else begin
      if (mem_req && !mem_ack && slow && wait_cnt < 3) begin
        wait_cnt <= wait_cnt + 1;
      end else if (mem_req && !mem_ack) begin
        wait_cnt <= 0;
        mem_ack  <= 1'b1;
        if (mem_we) begin
          mem[mem_addr[8:1]] <= mem_wdata;
        end else begin
          mem_rdata <= (mem_addr == RES_ADDR) ? res_q : mem[mem_addr[8:1]];
        end
      end
      if (kick || (conv_cmd_wr && conv_cmd != 16'h0000)) begin
        cmd_q    <= kick ? kick_cmd : conv_cmd;
        conv_cnt <= CONV_LAT;
      end else if (conv_cnt != 0) begin
        conv_cnt <= conv_cnt - 1;
        if (conv_cnt == 1) begin
          res_q     <= ~cmd_q;
          conv_done <= 1'b1;
        end
      end
    end
  end
endmodule : asts_partner
`default_nettype wire

// ### asts_server_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asts_server_tb;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} asts_row_t;
  logic        clk, reset, ce, psel, penable, pwrite, pready, pslverr, err, slow, kick;
  logic        conv_done, conv_cmd_wr, mem_req, mem_we, mem_ack, service_request;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] conv_cmd, mem_addr, mem_wdata, mem_rdata, kick_cmd;
  int          failures = 0;
  int          tests_run = 0;
  int          wr_cnt = 0;
  int          base;
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  asts_row_t   rows [10] = '{
    '{1'b1, 8'h04, 32'h000001FF, 32'h00000000, 1'b0}, '{1'b0, 8'h04, 32'h00000000, 32'h000000FF, 1'b0},
    '{1'b1, 8'h08, 32'hABCD1234, 32'h00000000, 1'b0}, '{1'b0, 8'h08, 32'h00000000, 32'h00001234, 1'b0},
    '{1'b1, 8'h10, 32'h00000020, 32'h00000000, 1'b0}, '{1'b0, 8'h10, 32'h00000000, 32'h00000020, 1'b0},
    '{1'b1, 8'h18, 32'h00000055, 32'h00000000, 1'b1}, '{1'b0, 8'h18, 32'h00000000, 32'h00000000, 1'b1},
    '{1'b1, 8'h14, 32'h00000006, 32'h00000000, 1'b0}, '{1'b0, 8'h14, 32'h00000000, 32'h00000000, 1'b0}};

  asts_server dut_u (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_cmd(conv_cmd), .conv_cmd_wr(conv_cmd_wr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_byte(), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .service_request(service_request));
  asts_partner part_u (.clk(clk), .reset(reset), .slow(slow), .kick(kick), .kick_cmd(kick_cmd),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .conv_cmd(conv_cmd), .conv_cmd_wr(conv_cmd_wr), .conv_done(conv_done));

  always #5 clk = ~clk;
  always @(posedge clk) if (conv_cmd_wr === 1'b1) wr_cnt <= wr_cnt + 1;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(name, exp, rd);
  endtask : rchk

  task automatic scan(input logic [8:0] ctrl, input logic [7:0] cnt, input logic [15:0] tbl, input logic [15:0] cmd);
    int n;
    apb(1'b1, asts_pkg::OFF_PTR1, {16'h0000, tbl});
    apb(1'b1, asts_pkg::OFF_PTR2, 32'h000000F0);
    apb(1'b1, asts_pkg::OFF_COUNT, {24'h000000, cnt});
    apb(1'b1, asts_pkg::OFF_CTRL, {23'h000000, ctrl});
    base = wr_cnt;
    @(posedge clk);
    kick     <= 1'b1;
    kick_cmd <= cmd;
    @(posedge clk);
    kick <= 1'b0;
    n = 0;
    while (service_request !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    // Late completions must land before judging
    repeat (30) @(posedge clk);
    chk("service_request", 32'h00000001, {31'h00000000, service_request});
  endtask : scan

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    slow = 1'b0;
    kick = 1'b0;
    kick_cmd = 16'h0000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("pslverr", {31'h00000000, rows[i].err}, {31'h00000000, err});
      if (!rows[i].wr) chk("prdata", rows[i].exp, rd);
    end
    $display("test registers done");
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    foreach (offs[i]) rchk("reset value", offs[i], (offs[i] == asts_pkg::OFF_BLOCK) ? 32'h00000001 : 32'h00000000);
    $display("test reset done");
    part_u.mem[16] = 16'h0011;
    part_u.mem[18] = 16'h0022;
    part_u.mem[20] = 16'h0000;
    scan(9'h1CB, 8'h03, 16'h0020, 16'h0007);
    chk("slot 0", 32'h0000FFF8, {16'h0000, part_u.mem[17]});
    chk("slot 0 value", 32'h000003FF, {16'h0000, part_u.mem[17]} >> 6);
    chk("slot 1", 32'h0000FFEE, {16'h0000, part_u.mem[19]});
    chk("slot 2", 32'h0000FFDD, {16'h0000, part_u.mem[21]});
    chk("conv_cmd", 32'h00000000, {16'h0000, conv_cmd});
    chk("command writes", 32'h00000003, 32'(wr_cnt - base));
    chk("service_request", 32'h00000001, {31'h00000000, service_request});
    rchk("table pointer", asts_pkg::OFF_PTR1, 32'h0000002C);
    rchk("cycle count", asts_pkg::OFF_COUNT, 32'h00000000);
    rchk("control", asts_pkg::OFF_CTRL, 32'h000000CB);
    rchk("status", asts_pkg::OFF_STAT, 32'h00000001);
    apb(1'b1, asts_pkg::OFF_STAT, 32'h00000001);
    rchk("status cleared", asts_pkg::OFF_STAT, 32'h00000000);
    $display("test scan update done");
    slow <= 1'b1;
    part_u.mem[32] = 16'h0033;
    scan(9'h1C3, 8'h02, 16'h0040, 16'h0009);
    chk("fixed slot", 32'h0000FFCC, {16'h0000, part_u.mem[33]});
    chk("command writes", 32'h00000002, 32'(wr_cnt - base));
    chk("conv_cmd", 32'h00000033, {16'h0000, conv_cmd});
    rchk("table pointer", asts_pkg::OFF_PTR1, 32'h00000040);
    rchk("cycle count", asts_pkg::OFF_COUNT, 32'h00000000);
    $display("test scan restore done");
    apb(1'b1, asts_pkg::OFF_STAT, 32'h00000001);
    part_u.mem[48] = 16'h1111;
    part_u.mem[49] = 16'h2222;
    apb(1'b1, asts_pkg::OFF_BLOCK, 32'h00000002);
    scan(9'h107, 8'h01, 16'h0060, 16'h0005);
    chk("block word 0", 32'h00001111, {16'h0000, part_u.mem[120]});
    chk("block word 1", 32'h00002222, {16'h0000, part_u.mem[121]});
    chk("command writes", 32'h00000000, 32'(wr_cnt - base));
    rchk("source pointer", asts_pkg::OFF_PTR1, 32'h00000060);
    rchk("destination pointer", asts_pkg::OFF_PTR2, 32'h000000F4);
    $display("test block done");
    scan(9'h1E3, 8'h01, 16'h0040, 16'h0001);
    chk("command writes", 32'h00000000, 32'(wr_cnt - base));
    rchk("cycle count", asts_pkg::OFF_COUNT, 32'h00000001);
    $display("test other mode done");
    give_verdict();
  end
endmodule : asts_server_tb
`default_nettype wire
